// ---- rtl/isp_cfg.svh ----
// Constant offsets, field positions, reset values and vector numbers of the priority unit
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISP_OFS_CTRL0 8'h00
`define ISP_OFS_SENSE 8'h04
`define ISP_OFS_STATUS 8'h08
`define ISP_OFS_PRIO_A 8'h0c
`define ISP_OFS_PRIO_B 8'h10
`define ISP_OFS_PRIO_C 8'h14
`define ISP_OFS_PRIO_D 8'h18
`define ISP_OFS_PRIO_E 8'h1c
`define ISP_OFS_ARB 8'h20

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ISP_NMI_EDGE_BIT 0
`define ISP_RST_CTRL0 16'h0000
`define ISP_RST_SENSE 16'h0000
`define ISP_RST_PRIO 16'h0000
`define ISP_RESP_OKAY 2'h0
`define ISP_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Sources, levels and vectors
// ----------------------------------------------------------------
`define ISP_NUM_PINS 8
`define ISP_NUM_PERIPH 18
`define ISP_NUM_SRC 29
`define ISP_LVL_NMI 5'h10
`define ISP_LVL_FIXED 5'h0f
`define ISP_MASK_TOP 4'hf
`define ISP_VEC_BREAK 8'h0c
`define ISP_VEC_NMI 8'h0b
`define ISP_VEC_DEBUG 8'h0d
`define ISP_VEC_PIN_LO 8'h40
`define ISP_VEC_PIN_HI 8'h50
`define ISP_VEC_PERIPH 8'h54

`endif

// ---- rtl/isp_pkg.sv ----
// Types shared by the interrupt source priority unit
package isp_pkg;

	// ----------------------------------------------------------------
	// Sense modes of an external request pin
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SENSE_LOW,
		SENSE_FALL,
		SENSE_RISE,
		SENSE_BOTH
	} isp_sense_t;

	// ----------------------------------------------------------------
	// Request to the CPU core and its acceptance
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [4:0] level;
		logic [7:0] vector;
		logic [3:0] new_mask;
		logic [9:0] table_offset;
	} isp_cpu_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] vector;
	} isp_cpu_ack_t;

endpackage

// ---- rtl/isp_unit.sv ----
// Interrupt source sensing, priority arbitration and AXI4-Lite register file
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "isp_cfg.svh"

// Overview of operation
// - Priority level zero masks a source
// - Pin NMI level 16, always accepted
// - NMI edge detected, polarity from control bit
// - Accepted NMI sets mask to 15
// - Each pin: low, fall, rise, both
// - Pin priorities from first two registers
// - Low mode requests only while pin low
// - Edge modes latch until accepted
// - Flag readable; cleared by zero after one
// - Accepted pin loads its priority as mask
// - Peripherals: own vector, priority from C-E
// - Accepted peripheral loads its level as mask
// - Break: level 15, edge latched, mask 15
// - Debug: level 15, edge latched, mask 15
// - Shared field: smaller vector wins
// - Priority fields reset to zero
// - Equal levels follow fixed default order
// - Fixed vector numbers for all sources
// - Table offset is four times vector
// - Forward only above current CPU mask
// - Pending edges cleared by reset, debug reset
// - Four-bit fields are plain binary levels
module isp_unit
	import isp_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt sources
	input wire logic nmi_pin,
	input wire logic [7:0] irq_pin,
	input wire logic break_req,
	input wire logic debug_req,
	input wire logic debug_reset,
	input wire logic [17:0] periph_req,
	// CPU core side
	input wire logic [3:0] cpu_mask_level,
	input wire isp_cpu_ack_t cpu_ack,
	output isp_cpu_req_t cpu_req
);

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	function automatic logic [7:0] src_vector(input int i);
		if (i == 0) begin
			return `ISP_VEC_BREAK;
		end else if (i == 1) begin
			return `ISP_VEC_NMI;
		end else if (i == 2) begin
			return `ISP_VEC_DEBUG;
		end else if (i < 7) begin
			return `ISP_VEC_PIN_LO + 8'(i - 3);
		end else if (i < 11) begin
			return `ISP_VEC_PIN_HI + 8'(i - 7);
		end else begin
			return `ISP_VEC_PERIPH + 8'(i - 11);
		end
	endfunction

	function automatic int periph_field(input int p);
		if (p < 4) begin
			return p;
		end else if (p < 16) begin
			return 4 + (p - 4) / 4;
		end else begin
			return p - 8;
		end
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] interrupt_control_reg0;
	logic [15:0] pin_sense_control;
	logic [15:0] priority_reg_pins_low;
	logic [15:0] priority_reg_pins_high;
	logic [15:0] priority_reg_periph_c;
	logic [15:0] priority_reg_periph_d;
	logic [15:0] priority_reg_periph_e;
	logic [7:0] pin_pend;
	logic [7:0] flag_read_one;
	logic nmi_pend;
	logic break_pend;
	logic debug_pend;
	logic nmi_prev;
	logic break_prev;
	logic debug_prev;
	logic [7:0] pin_prev;
	logic aw_got;
	logic w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// ----------------------------------------------------------------
	// Source sensing
	// ----------------------------------------------------------------
	wire nmi_edge_select = interrupt_control_reg0[`ISP_NMI_EDGE_BIT];
	wire nmi_hit = nmi_edge_select ? (nmi_pin & ~nmi_prev) : (~nmi_pin & nmi_prev);
	wire break_hit = break_req & ~break_prev;
	wire debug_hit = debug_req & ~debug_prev;
	wire [31:0] pin_prio = {priority_reg_pins_low, priority_reg_pins_high};
	wire [47:0] periph_prio = {priority_reg_periph_c, priority_reg_periph_d,
		priority_reg_periph_e};
	wire ack_hit = cpu_ack.valid;
	logic [7:0] pin_edge_hit;
	logic [7:0] pin_level_mode;
	logic [7:0] pin_request_flag;
	logic [7:0] pin_ack;

	genvar g;
	generate
		for (g = 0; g < `ISP_NUM_PINS; g++) begin : g_pin
			wire isp_sense_t mode = isp_sense_t'(pin_sense_control[2*g+1 -: 2]);
			assign pin_level_mode[g] = (mode == SENSE_LOW);
			assign pin_edge_hit[g] = (mode == SENSE_FALL) ? (~irq_pin[g] & pin_prev[g]) :
				(mode == SENSE_RISE) ? (irq_pin[g] & ~pin_prev[g]) :
				(mode == SENSE_BOTH) ? (irq_pin[g] ^ pin_prev[g]) : 1'b0;
			assign pin_request_flag[g] = pin_level_mode[g] ? ~irq_pin[g] : pin_pend[g];
			assign pin_ack[g] = ack_hit && cpu_ack.vector == src_vector(g + 3);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	logic [4:0] src_level [`ISP_NUM_SRC];
	logic [`ISP_NUM_SRC-1:0] src_active;
	logic [4:0] win_level;
	logic [7:0] win_vector;
	logic win_valid;

	always_comb begin
		src_level[1] = `ISP_LVL_NMI;
		src_level[0] = `ISP_LVL_FIXED;
		src_level[2] = `ISP_LVL_FIXED;
		src_active[0] = break_pend;
		src_active[1] = nmi_pend;
		src_active[2] = debug_pend;
		for (int k = 0; k < `ISP_NUM_PINS; k++) begin
			src_level[k+3] = {1'b0, pin_prio[31-4*k -: 4]};
			src_active[k+3] = pin_request_flag[k] && pin_prio[31-4*k -: 4] != 4'h0;
		end
		for (int p = 0; p < `ISP_NUM_PERIPH; p++) begin
			src_level[p+11] = {1'b0, periph_prio[47-4*periph_field(p) -: 4]};
			src_active[p+11] = periph_req[p] && src_level[p+11] != 5'h00;
		end
	end

	always_comb begin
		win_level = 5'h00;
		win_vector = 8'h00;
		win_valid = 1'b0;
		// First in default order wins ties
		for (int i = 0; i < `ISP_NUM_SRC; i++) begin
			if (src_active[i] && (!win_valid || src_level[i] > win_level)) begin
				win_valid = 1'b1;
				win_level = src_level[i];
				win_vector = src_vector(i);
			end
		end
	end

	// Strictly above mask; 16 always passes
	wire fwd = win_valid && win_level > {1'b0, cpu_mask_level};
	wire [3:0] next_mask = win_level[4] ? `ISP_MASK_TOP : win_level[3:0];
	wire [9:0] next_offset = {win_vector, 2'b00};

	// ----------------------------------------------------------------
	// AXI4-Lite decode
	// ----------------------------------------------------------------
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire have_aw = aw_got | aw_hs;
	wire have_w = w_got | w_hs;
	wire do_write = have_aw & have_w & ~s_axi_bvalid;
	wire [7:0] wr_addr = aw_got ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_got ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_got ? w_strb : s_axi_wstrb;
	wire wr_ctrl0 = do_write && wr_addr == `ISP_OFS_CTRL0;
	wire wr_sense = do_write && wr_addr == `ISP_OFS_SENSE;
	wire wr_status = do_write && wr_addr == `ISP_OFS_STATUS && wr_strb[0];
	wire wr_prio_a = do_write && wr_addr == `ISP_OFS_PRIO_A;
	wire wr_prio_b = do_write && wr_addr == `ISP_OFS_PRIO_B;
	wire wr_prio_c = do_write && wr_addr == `ISP_OFS_PRIO_C;
	wire wr_prio_d = do_write && wr_addr == `ISP_OFS_PRIO_D;
	wire wr_prio_e = do_write && wr_addr == `ISP_OFS_PRIO_E;
	wire wr_ok = wr_ctrl0 | wr_sense | (do_write && wr_addr == `ISP_OFS_STATUS) |
		wr_prio_a | wr_prio_b | wr_prio_c | wr_prio_d | wr_prio_e |
		(do_write && wr_addr == `ISP_OFS_ARB);
	wire rd_status = ar_hs && s_axi_araddr == `ISP_OFS_STATUS;
	// Clear only a flag seen as one
	wire [7:0] status_clear = wr_status ? (~wr_data[7:0] & flag_read_one & ~pin_level_mode) :
		8'h00;
	logic [31:0] rd_data;
	logic rd_ok;

	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`ISP_OFS_CTRL0: rd_data = {16'h0000, interrupt_control_reg0};
			`ISP_OFS_SENSE: rd_data = {16'h0000, pin_sense_control};
			`ISP_OFS_STATUS: rd_data = {24'h000000, pin_request_flag};
			`ISP_OFS_PRIO_A: rd_data = {16'h0000, priority_reg_pins_low};
			`ISP_OFS_PRIO_B: rd_data = {16'h0000, priority_reg_pins_high};
			`ISP_OFS_PRIO_C: rd_data = {16'h0000, priority_reg_periph_c};
			`ISP_OFS_PRIO_D: rd_data = {16'h0000, priority_reg_periph_d};
			`ISP_OFS_PRIO_E: rd_data = {16'h0000, priority_reg_periph_e};
			`ISP_OFS_ARB: rd_data = {11'h000, win_valid, 3'h0, win_level, cpu_req.new_mask,
				win_vector};
			default: begin
				rd_data = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ISP_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `ISP_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~have_aw & ~s_axi_bvalid;
			s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~have_w & ~s_axi_bvalid;
			aw_got <= have_aw & ~do_write;
			w_got <= have_w & ~do_write;
			if (aw_hs) begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `ISP_RESP_OKAY : `ISP_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_ok ? `ISP_RESP_OKAY : `ISP_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control and priority registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_control_reg0 <= `ISP_RST_CTRL0;
			pin_sense_control <= `ISP_RST_SENSE;
			priority_reg_pins_low <= `ISP_RST_PRIO;
			priority_reg_pins_high <= `ISP_RST_PRIO;
			priority_reg_periph_c <= `ISP_RST_PRIO;
			priority_reg_periph_d <= `ISP_RST_PRIO;
			priority_reg_periph_e <= `ISP_RST_PRIO;
		end else begin
			if (wr_ctrl0) begin
				interrupt_control_reg0 <= merge(interrupt_control_reg0, wr_data, wr_strb) &
					16'h0001;
			end
			if (wr_sense) begin
				pin_sense_control <= merge(pin_sense_control, wr_data, wr_strb);
			end
			if (wr_prio_a) begin
				priority_reg_pins_low <= merge(priority_reg_pins_low, wr_data, wr_strb);
			end
			if (wr_prio_b) begin
				priority_reg_pins_high <= merge(priority_reg_pins_high, wr_data, wr_strb);
			end
			if (wr_prio_c) begin
				priority_reg_periph_c <= merge(priority_reg_periph_c, wr_data, wr_strb);
			end
			if (wr_prio_d) begin
				priority_reg_periph_d <= merge(priority_reg_periph_d, wr_data, wr_strb);
			end
			if (wr_prio_e) begin
				priority_reg_periph_e <= merge(priority_reg_periph_e, wr_data, wr_strb) &
					16'hff00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pending latches
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		// Reset or debug reset drops pending edges
		if (!aresetn || debug_reset) begin
			nmi_pend <= 1'b0;
			break_pend <= 1'b0;
			debug_pend <= 1'b0;
			pin_pend <= 8'h00;
			flag_read_one <= 8'h00;
		end else begin
			nmi_pend <= nmi_hit | (nmi_pend & ~(ack_hit && cpu_ack.vector == `ISP_VEC_NMI));
			break_pend <= break_hit |
				(break_pend & ~(ack_hit && cpu_ack.vector == `ISP_VEC_BREAK));
			debug_pend <= debug_hit |
				(debug_pend & ~(ack_hit && cpu_ack.vector == `ISP_VEC_DEBUG));
			// Pin latch, cleared by accept or flag write
			pin_pend <= pin_edge_hit | (pin_pend & ~pin_ack & ~status_clear & ~pin_level_mode);
			flag_read_one <= (flag_read_one & ~status_clear) |
				(rd_status ? pin_request_flag : 8'h00);
		end
	end

	// ----------------------------------------------------------------
	// Edge history and CPU request
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nmi_prev <= 1'b1;
			break_prev <= 1'b0;
			debug_prev <= 1'b0;
			pin_prev <= 8'hff;
			cpu_req <= '0;
		end else begin
			nmi_prev <= nmi_pin;
			break_prev <= break_req;
			debug_prev <= debug_req;
			pin_prev <= irq_pin;
			cpu_req.valid <= fwd;
			cpu_req.level <= win_level;
			cpu_req.vector <= win_vector;
			cpu_req.new_mask <= next_mask;
			cpu_req.table_offset <= next_offset;
		end
	end

endmodule // isp_unit

// ---- verif/isp_cpu_model.sv ----
// CPU core model that accepts forwarded requests and tracks its mask level
`timescale 1ns/10ps
module isp_cpu_model
	import isp_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench controls
	input wire logic ack_en,
	input wire logic [3:0] ack_dly,
	input wire logic ret,
	input wire logic [3:0] ret_mask,
	// Controller link
	input wire isp_cpu_req_t cpu_req,
	output logic [3:0] cpu_mask_level,
	output isp_cpu_ack_t cpu_ack
);
	logic [3:0] wait_cnt;
	wire take = ack_en && cpu_req.valid && !cpu_ack.valid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_mask_level <= 4'h0;
			cpu_ack <= '0;
			wait_cnt <= 4'h0;
		end else begin
			cpu_ack <= '0;
			wait_cnt <= take ? wait_cnt + 4'h1 : 4'h0;
			if (ret) begin
				cpu_mask_level <= ret_mask;
			end else if (take && wait_cnt >= ack_dly) begin
				cpu_ack <= {1'b1, cpu_req.vector};
				cpu_mask_level <= cpu_req.new_mask;
			end
		end
	end
endmodule // isp_cpu_model

// ---- verif/isp_unit_asserts.sv ----
// Port checks for the interrupt source priority unit
`timescale 1ns/10ps
`include "isp_cfg.svh"
module isp_unit_asserts
	import isp_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// CPU core side
	input wire logic [3:0] cpu_mask_level,
	input wire isp_cpu_req_t cpu_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	wr_resp_a: assert property (wr_taken |=> s_axi_bvalid)
		else $error("write response missing");
	rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read response missing");
	lvl_zero_a: assert property (cpu_req.valid |-> cpu_req.level != 5'h00)
		else $error("level zero forwarded");
	above_mask_a: assert property (cpu_req.valid |-> cpu_req.level > {1'b0, $past(cpu_mask_level)})
		else $error("request not above mask");
	nmi_fixed_a: assert property (cpu_req.valid && cpu_req.vector == `ISP_VEC_NMI |-> cpu_req.level == 5'h10 && cpu_req.new_mask == 4'hf)
		else $error("nmi level or mask wrong");
	brk_dbg_a: assert property (cpu_req.valid && cpu_req.vector inside {`ISP_VEC_BREAK, `ISP_VEC_DEBUG} |-> cpu_req.level == 5'h0f && cpu_req.new_mask == 4'hf)
		else $error("fixed level fifteen wrong");
	mask_copy_a: assert property (cpu_req.valid && cpu_req.level != 5'h10 |-> cpu_req.new_mask == cpu_req.level[3:0])
		else $error("new mask differs from level");
	tbl_offset_a: assert property (cpu_req.valid |-> cpu_req.table_offset == {cpu_req.vector, 2'b00})
		else $error("table offset wrong");
	vec_range_a: assert property (cpu_req.valid |-> cpu_req.vector inside {[8'h0b:8'h0d], [8'h40:8'h43], [8'h50:8'h65]})
		else $error("vector outside map");
endmodule // isp_unit_asserts

bind isp_unit isp_unit_asserts i_isp_unit_asserts (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .cpu_mask_level, .cpu_req);

// ---- verif/tb.sv ----
// Self-checking bench for the interrupt source priority unit
`timescale 1ns/10ps
`include "isp_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
module tb
	import isp_pkg::*;
;
	// ----
	// Stimulus and observed signals
	// ----
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0, ack_dly = '0, ret_mask = '0, cpu_mask_level;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic nmi_pin = 1, break_req = 0, debug_req = 0, debug_reset = 0, ack_en = 0, ret = 0;
	logic [7:0] irq_pin = 8'hff;
	logic [17:0] periph_req = '0;
	isp_cpu_ack_t cpu_ack;
	isp_cpu_req_t cpu_req;
	int fail_count = 0, total_checks = 0;

	always #5 aclk = ~aclk;

	isp_unit i_isp_unit (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_pin, .irq_pin, .break_req,
		.debug_req, .debug_reset, .periph_req, .cpu_mask_level, .cpu_ack, .cpu_req);
	isp_cpu_model i_isp_cpu_model (.aclk, .aresetn, .ack_en, .ack_dly, .ret, .ret_mask,
		.cpu_req, .cpu_mask_level, .cpu_ack);

	// ----
	// Bus and link tasks
	// ----
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
		int n;
		logic aw, w;
		aw = 0;
		w = 0;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
			n++;
		end while (!(aw && w) && n < 50);
		for (; !s_axi_bvalid && n < 99; n++) @(posedge aclk);
		`CHK(s_axi_bvalid, 1'b1)
		`CHK(s_axi_bresp, er)
		s_axi_bready <= 0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 50 && !(s_axi_arready && s_axi_arvalid); n++) @(posedge aclk);
		s_axi_arvalid <= 0;
		for (; n < 99 && !s_axi_rvalid; n++) @(posedge aclk);
		`CHK(s_axi_rvalid, 1'b1)
		`CHK(s_axi_rdata, ed)
		`CHK(s_axi_rresp, er)
		s_axi_rready <= 0;
	endtask

	task automatic pin(input int k, input logic v);
		@(posedge aclk);
		irq_pin[k] <= v;
	endtask

	task automatic set_mask(input logic [3:0] m);
		@(posedge aclk);
		ret_mask <= m;
		ret <= 1;
		@(posedge aclk);
		ret <= 0;
	endtask

	task automatic accept;
		@(posedge aclk);
		ack_en <= 1;
		for (int n = 0; n < 40 && cpu_ack.valid !== 1'b1; n++) @(posedge aclk);
		`CHK(cpu_ack.valid, 1'b1)
		ack_en <= 0;
		set_mask(4'h0);
	endtask

	task automatic req(input logic [7:0] v, input logic [4:0] l);
		for (int n = 0; n < 40 && !(cpu_req.valid === 1'b1 && cpu_req.vector === v); n++)
			@(posedge aclk);
		`CHK(cpu_req.vector, v)
		`CHK(cpu_req.level, l)
		`CHK(cpu_req.new_mask, ((l == 5'h10) ? 4'hf : l[3:0]))
		`CHK(cpu_req.table_offset, (10'(v) * 4))
	endtask

	task automatic wreq(input logic v);
		for (int n = 0; n < 40 && cpu_req.valid !== v; n++) @(posedge aclk);
		`CHK(cpu_req.valid, v)
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		for (int i = 0; i < 5; i++)
			rdc(8'h0c + 8'(4 * i), 32'h0); // zero levels
		rdc(8'h24, 32'h0, `ISP_RESP_SLVERR);
		wr(8'h24, 16'hffff, `ISP_RESP_SLVERR);
		wr(`ISP_OFS_SENSE, {8'h00, SENSE_BOTH, SENSE_LOW, SENSE_LOW, SENSE_FALL});
		wr(`ISP_OFS_PRIO_A, 16'h5703);
		rdc(`ISP_OFS_PRIO_A, 32'h5703); // pin fields
		wr(`ISP_OFS_PRIO_C, 16'h9000);
		wr(`ISP_OFS_PRIO_D, 16'h9000);
		`CHK(cpu_req.valid, 1'b0) // idle
	endtask

	task automatic t_pins;
		pin(0, 0);
		pin(0, 1);
		req(8'h40, 5'h05); // latched fall
		rdc(`ISP_OFS_STATUS, 32'h01); // flag set
		`CHK(cpu_req.valid, 1'b1) // held
		accept;
		rdc(`ISP_OFS_STATUS, 32'h00); // latch cleared
		pin(1, 0);
		req(8'h41, 5'h07); // low level
		rdc(`ISP_OFS_STATUS, 32'h02); // live flag
		pin(1, 1);
		wreq(1'b0); // drops when high
		pin(2, 0);
		rdc(`ISP_OFS_STATUS, 32'h04); // live flag
		`CHK(cpu_req.valid, 1'b0) // level zero
		pin(2, 1);
	endtask

	task automatic t_fixed;
		wr(`ISP_OFS_CTRL0, 16'h0001);
		set_mask(4'hf);
		nmi_pin <= 0;
		rdc(`ISP_OFS_STATUS, 32'h00);
		`CHK(cpu_req.valid, 1'b0) // falling ignored
		nmi_pin <= 1;
		req(`ISP_VEC_NMI, 5'h10); // above mask
		accept;
		wreq(1'b0); // nmi cleared
		ack_dly <= 4'h3;
		break_req <= 1;
		debug_req <= 1;
		req(`ISP_VEC_BREAK, 5'h0f); // break first
		accept;
		break_req <= 0;
		debug_req <= 0;
		req(`ISP_VEC_DEBUG, 5'h0f); // debug next
		accept;
		wreq(1'b0); // both cleared
	endtask

	task automatic t_periph;
		periph_req[5:4] <= 2'b11;
		req(8'h58, 5'h09); // smaller vector
		periph_req[0] <= 1;
		req(8'h54, 5'h09); // default order
		set_mask(4'h9);
		wreq(1'b0); // equal ignored
		set_mask(4'h8);
		req(8'h54, 5'h09); // above mask
		rdc(`ISP_OFS_ARB, 32'h00109954); // arbiter view
		wr(`ISP_OFS_PRIO_E, 16'hab00);
		periph_req[17:16] <= 2'b11;
		req(8'h65, 5'h0b); // last field
		periph_req <= '0;
		set_mask(4'h0);
		wreq(1'b0);
	endtask

	task automatic t_both;
		pin(3, 0);
		req(8'h43, 5'h03); // both edges
		rdc(`ISP_OFS_STATUS, 32'h08); // flag read
		wr(`ISP_OFS_STATUS, 16'h0000);
		wreq(1'b0); // cancelled
		pin(3, 1);
		req(8'h43, 5'h03); // rising too
		wr(`ISP_OFS_STATUS, 16'h0000);
		`CHK(cpu_req.valid, 1'b1) // unread kept
		@(posedge aclk);
		debug_reset <= 1;
		@(posedge aclk);
		debug_reset <= 0;
		wreq(1'b0); // debug reset clears
	endtask

	// ----
	// Sequence, watchdog and verdict
	// ----
	task automatic final_report;
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		t_regs();
		t_pins();
		t_fixed();
		t_periph();
		t_both();
		final_report();
	end

	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		$display("ERROR %0t: run did not finish", $time);
		final_report();
	end
endmodule // tb
